/* File: bench/spi_config_port_checker.sv */
// Checker for the serial configuration port: data pin enable, pin
// release, soft reset recovery and reset defaults.
// Assumes it is bound to spi_config_port and sees only its ports.
`timescale 1ns/1ns
module spi_config_port_checker
  import spi_cfg_pkg::*;
#(
  parameter int RECOVER_CYCLES = RECOVER_CYCLES_DEF
) (
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire logic i_select_active_low,
  input wire logic o_sdio_oe,
  input wire logic o_pins_released,
  input wire logic o_lsb_first,
  input wire logic o_recovering,
  input wire logic [31:0] o_fast_detect_control,
  input wire logic [15:0] o_output_format_mode
);
  logic [7:0] hi_cnt_q;
  logic [7:0] lo_cnt_q;
  logic [31:0] rec_cnt_q;

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);

  // Saturating run lengths of select; raw pin, so limits carry slack
  always_ff @(posedge i_sys_clk) begin
    if (i_reset || !i_select_active_low) hi_cnt_q <= 8'h00;
    else if (hi_cnt_q != 8'hff) hi_cnt_q <= hi_cnt_q + 8'h01;
  end
  always_ff @(posedge i_sys_clk) begin
    if (i_reset || i_select_active_low) lo_cnt_q <= 8'h00;
    else if (lo_cnt_q != 8'hff) lo_cnt_q <= lo_cnt_q + 8'h01;
  end
  // Length of the current recovery run
  always_ff @(posedge i_sys_clk) begin
    if (i_reset || !o_recovering) rec_cnt_q <= 32'h0;
    else rec_cnt_q <= rec_cnt_q + 32'h1;
  end

  sequence s_defaults;
    o_output_format_mode == {2{RST_OUTPUT_FORMAT_MODE}} && o_fast_detect_control == 32'h0
      && !o_lsb_first;
  endsequence
  sequence s_recover_done;
    rec_cnt_q == RECOVER_CYCLES;
  endsequence

  a_oe_needs_select: assert property (o_sdio_oe |-> !i_select_active_low)
    else $error("data pin driven while deselected");
  a_oe_when_released: assert property (o_pins_released |-> !o_sdio_oe)
    else $error("data pin driven while pins released");
  a_release_after_idle: assert property (hi_cnt_q > STALL_CYCLES + 5 |-> o_pins_released)
    else $error("pins not released after long deselect");
  a_low_keeps_enabled: assert property (lo_cnt_q >= 8'd5 |-> !o_pins_released)
    else $error("pins released while selected");
  a_stall_no_release: assert property ($rose(o_pins_released) |-> hi_cnt_q >= STALL_CYCLES)
    else $error("short stall released the pins");
  a_reset_loads_defaults: assert property ($fell(i_reset) |-> s_defaults ##0 o_pins_released)
    else $error("outputs not at defaults after reset");
  a_recover_holds_defaults: assert property (o_recovering && $past(o_recovering) |-> s_defaults)
    else $error("registers changed during recovery");
  a_recover_length: assert property ($fell(o_recovering) |-> s_recover_done)
    else $error("recovery length wrong");
  a_recover_bound: assert property (rec_cnt_q <= RECOVER_CYCLES)
    else $error("recovery runs too long");
endmodule : spi_config_port_checker

bind spi_config_port spi_config_port_checker #(.RECOVER_CYCLES(RECOVER_CYCLES)) u_chk (
  .i_sys_clk(i_sys_clk),
  .i_reset(i_reset),
  .i_select_active_low(i_select_active_low),
  .o_sdio_oe(o_sdio_oe),
  .o_pins_released(o_pins_released),
  .o_lsb_first(o_lsb_first),
  .o_recovering(o_recovering),
  .o_fast_detect_control(o_fast_detect_control),
  .o_output_format_mode(o_output_format_mode)
);

/* File: bench/spi_config_port_pair_addressing_tb_top.sv */
// Testbench for the serial configuration port with pair addressing.
// Assumes the host model drives the link; the bench drives reset.
`timescale 1ns/1ns
module spi_config_port_pair_addressing_tb_top;
  import spi_cfg_pkg::*;
  localparam int REC = 20;
  logic i_sys_clk = 1'b0;
  logic i_reset;
  logic sclk, select_active_low, host_sdio, sdio_line, sdio_out, sdio_oe;
  logic pins_released, lsb_first, recovering, dp_reset;
  logic seen_rec = 1'b0;
  logic seen_dp = 1'b0;
  logic [31:0] fast_det, test_mode;
  logic [15:0] out_fmt, q;
  int err_total = 0;
  int checks_done = 0;

  initial begin
    forever #5 i_sys_clk = ~i_sys_clk;
  end
  // Wire level: device when enabled, else the host's value
  // An enable still unknown before the first select edge counts as released
  assign sdio_line = (sdio_oe === 1'b1) ? sdio_out : host_sdio;

  spi_host_model u_spi_host_model (.i_sdio_out(sdio_out), .i_sdio_oe(sdio_oe), .o_sclk(sclk),
    .o_select_active_low(select_active_low), .o_sdio(host_sdio));
  spi_config_port #(.RECOVER_CYCLES(REC)) u_spi_config_port (.i_sys_clk(i_sys_clk),
    .i_reset(i_reset), .i_serial_clk(sclk), .i_select_active_low(select_active_low),
    .i_sdio_in(sdio_line), .o_sdio_out(sdio_out), .o_sdio_oe(sdio_oe),
    .o_pins_released(pins_released), .o_lsb_first(lsb_first), .o_recovering(recovering),
    .o_datapath_reset(dp_reset), .o_fast_detect_control(fast_det),
    .o_test_mode_select(test_mode), .o_output_format_mode(out_fmt));

  // Pulses are short, so remember that they happened
  always @(posedge i_sys_clk) begin
    if (recovering === 1'b1) seen_rec <= 1'b1;
    if (dp_reset === 1'b1) seen_dp <= 1'b1;
  end

  task automatic wr(input logic [14:0] a, input logic [15:0] d, input int n, input logic lsb,
                    input logic stall);
    logic [15:0] r;
    u_spi_host_model.xfer(1'b0, a, d, n, lsb, stall, r);
  endtask : wr
  task automatic rd(input logic [14:0] a, input int n, input logic lsb, input logic stall);
    u_spi_host_model.xfer(1'b1, a, 16'h0000, n, lsb, stall, q);
  endtask : rd
  task automatic check_rd(input string nm, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask : check_rd
  task automatic check_port(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask : check_port
  task automatic complete_run();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : complete_run

  // Whole sequence takes well under 100 us
  initial begin
    #500000;
    err_total++;
    complete_run();
  end

  initial begin
    i_reset <= 1'b1;
    repeat (4) @(posedge i_sys_clk);
    i_reset <= 1'b0;
    repeat (3) @(posedge i_sys_clk);
    check_port("out_fmt", 32'h0101, out_fmt);
    check_port("released", 32'h1, pins_released);
    check_port("lsb_first", 32'h0, lsb_first);
    rd(ADDR_OUTPUT_FORMAT_MODE, 2, 1'b0, 1'b0);
    check_rd("fmt_stream", 16'h0100, q);
    // only mapped addresses are ever written
    wr(ADDR_PAIR_SELECT_INDEX, 16'h0100, 1, 1'b0, 1'b0);
    wr(ADDR_CHANNEL_SELECT_INDEX, 16'h0100, 1, 1'b0, 1'b0);
    wr(ADDR_TEST_MODE_SELECT, 16'h5b00, 1, 1'b0, 1'b0);
    check_port("test_mode", 32'h0000005b, test_mode);
    wr(ADDR_OUTPUT_FORMAT_MODE, 16'h0000, 1, 1'b0, 1'b0);
    check_port("out_fmt_pair", 32'h0100, out_fmt);
    wr(ADDR_PAIR_SELECT_INDEX, 16'h0303, 2, 1'b0, 1'b1);
    rd(ADDR_PAIR_SELECT_INDEX, 2, 1'b0, 1'b1);
    check_rd("index_pair", 16'h0303, q);
    wr(ADDR_FAST_DETECT_CONTROL, 16'h3c00, 1, 1'b0, 1'b0);
    check_port("fast_all", 32'h3c3c3c3c, fast_det);
    wr(ADDR_CHANNEL_SELECT_INDEX, 16'h0200, 1, 1'b0, 1'b0);
    wr(ADDR_FAST_DETECT_CONTROL, 16'h7100, 1, 1'b0, 1'b0);
    check_port("fast_chan_b", 32'h713c713c, fast_det);
    wr(ADDR_CHANNEL_SELECT_INDEX, 16'h0300, 1, 1'b0, 1'b0);
    rd(ADDR_FAST_DETECT_CONTROL, 1, 1'b0, 1'b0);
    check_rd("fast_first", 16'h3c00, q);
    wr(ADDR_PORT_CONFIG_A, 16'h4200, 1, 1'b0, 1'b0);
    check_port("lsb_on", 32'h1, lsb_first);
    rd(ADDR_TEST_MODE_SELECT, 1, 1'b1, 1'b0);
    check_rd("lsb_read", 16'h5b00, q);
    wr(ADDR_PORT_CONFIG_A, 16'h0000, 1, 1'b1, 1'b0);
    check_port("lsb_off", 32'h0, lsb_first);
    wr(ADDR_PORT_CONFIG_B, 16'h0200, 1, 1'b0, 1'b0);
    check_port("dp_pulse", 32'h1, seen_dp);
    wr(ADDR_PORT_CONFIG_A, 16'h8100, 1, 1'b0, 1'b0);
    check_port("recovered", 32'h2, {seen_rec, recovering});
    check_port("soft_fmt", 32'h0101, out_fmt);
    check_port("soft_fast", 32'h0, fast_det);
    complete_run();
  end
endmodule : spi_config_port_pair_addressing_tb_top

/* File: bench/spi_host_model.sv */
// Serial host model: frames with instruction, data bytes and stalls.
// Assumes the bench resolves the data wire from both drivers.
`timescale 1ns/1ns
module spi_host_model (
  input wire logic i_sdio_out,
  input wire logic i_sdio_oe,
  output logic o_sclk,
  output logic o_select_active_low,
  output logic o_sdio
);
  logic lclk = 1'b0;
  logic run_q = 1'b0;
  // Holds the serial clock high through a stall so its release gives a falling edge
  logic park_q = 1'b0;

  // 32 ns link reference, unrelated to the system clock
  initial begin
    #7;
    forever #16 lclk = ~lclk;
  end
  assign o_sclk = (lclk & run_q) | park_q;
  initial begin
    o_select_active_low = 1'b1;
    o_sdio = 1'b0;
  end

  // One byte; a released line toggles so no stale value passes
  task automatic put_byte(input logic [7:0] b, input logic lsb, input logic drive,
                          output logic [7:0] q);
    for (int i = 0; i < 8; i++) begin
      @(negedge lclk);
      o_sdio <= drive ? (lsb ? b[i] : b[7-i]) : ~o_sdio;
      run_q <= 1'b1;
      @(posedge lclk);
      q[lsb ? i : 7 - i] = i_sdio_oe ? i_sdio_out : 1'bx;
    end
  endtask : put_byte

  task automatic xfer(input logic rd, input logic [14:0] a, input logic [15:0] d, input int n,
                      input logic lsb, input logic stall, output logic [15:0] q);
    logic [7:0] r;
    q = 16'h0000;
    @(negedge lclk);
    o_select_active_low <= 1'b0;
    repeat (2) @(negedge lclk);
    put_byte(lsb ? {a[14:8], rd} : {rd, a[14:8]}, lsb, 1'b1, r);
    put_byte(a[7:0], lsb, 1'b1, r);
    for (int k = 0; k < n; k++) begin
      // brief deselect between bytes
      // Clock parks high, so the device re-drives a read on the release edge
      if (stall && k > 0) begin
        park_q <= 1'b1;
        @(negedge lclk);
        run_q <= 1'b0;
        o_select_active_low <= 1'b1;
        repeat (2) @(negedge lclk);
        o_select_active_low <= 1'b0;
        @(negedge lclk);
        park_q <= 1'b0;
      end
      put_byte(d[8 * (1 - k) +: 8], lsb, !rd, r);
      q[8 * (1 - k) +: 8] = r;
    end
    @(negedge lclk);
    run_q <= 1'b0;
    o_select_active_low <= 1'b1;
    o_sdio <= ~o_sdio;
    // Long deselect so the next frame starts fresh
    repeat (40) @(posedge lclk);
  endtask : xfer
endmodule : spi_host_model

/* File: rtl/level_sync.sv */
// Two-flop synchroniser for levels entering a clock domain.
// Assumes each input bit changes at most once per few destination clocks.
`timescale 1ns/1ns
module level_sync #(
  parameter int WIDTH = 1
) (
  input wire logic i_clk,
  input wire logic [WIDTH-1:0] i_level,
  output logic [WIDTH-1:0] o_level
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  // First stage feeds only the second stage
  always_ff @(posedge i_clk) begin
    meta_q <= i_level;
    sync_q <= meta_q;
  end

  assign o_level = sync_q;

endmodule : level_sync

/* File: rtl/spi_cfg_pkg.sv */
// Package for the serial configuration port: address map, field
// positions, reset values, timing counts and the link phase type.
// Assumes a 100 MHz system clock and 15-bit register addresses.
package spi_cfg_pkg;

  // Address and data widths, pair and channel counts
  localparam int ADDR_W = 15;
  localparam int DATA_W = 8;
  localparam int NUM_PAIRS = 2;
  localparam int NUM_CHANS = 4;

  // Register offsets
  localparam logic [14:0] ADDR_PORT_CONFIG_A = 15'h0000;
  localparam logic [14:0] ADDR_PORT_CONFIG_B = 15'h0001;
  localparam logic [14:0] ADDR_CHANNEL_SELECT_INDEX = 15'h0008;
  localparam logic [14:0] ADDR_PAIR_SELECT_INDEX = 15'h0009;
  localparam logic [14:0] ADDR_FAST_DETECT_CONTROL = 15'h0247;
  localparam logic [14:0] ADDR_TEST_MODE_SELECT = 15'h0550;
  localparam logic [14:0] ADDR_OUTPUT_FORMAT_MODE = 15'h0561;

  // Field positions of port_config_a (each function has a mirror bit)
  localparam int CFGA_SOFT_RESET_LO = 0;
  localparam int CFGA_LSB_FIRST = 1;
  localparam int CFGA_ASCEND = 2;
  localparam int CFGA_ASCEND_MIRROR = 5;
  localparam int CFGA_LSB_FIRST_MIRROR = 6;
  localparam int CFGA_SOFT_RESET_HI = 7;
  // Field positions of port_config_b
  localparam int CFGB_DATAPATH_RESET = 1;
  localparam int CFGB_SINGLE_INSTR = 7;

  // Reset values
  localparam logic [7:0] RST_PORT_CONFIG_A = 8'h00;
  localparam logic [7:0] RST_PORT_CONFIG_B = 8'h00;
  localparam logic [1:0] RST_CHANNEL_SELECT = 2'h3;
  localparam logic [1:0] RST_PAIR_SELECT = 2'h3;
  localparam logic [7:0] RST_FAST_DETECT_CONTROL = 8'h00;
  localparam logic [7:0] RST_TEST_MODE_SELECT = 8'h00;
  localparam logic [7:0] RST_OUTPUT_FORMAT_MODE = 8'h01;

  // Timing: system clock period, soft reset recovery, stall window
  localparam int CLK_PERIOD_NS = 10;
  localparam int SOFT_RESET_TIME_NS = 5000000;
  localparam int RECOVER_CYCLES_DEF =
    (SOFT_RESET_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STALL_TIME_NS = 1000;
  localparam int STALL_CYCLES = STALL_TIME_NS / CLK_PERIOD_NS;

  // Position of the link inside a transaction
  typedef enum logic [1:0] {
    PH_INSTR_HI,
    PH_INSTR_LO,
    PH_DATA
  } link_phase_type;

endpackage : spi_cfg_pkg

/* File: rtl/spi_config_port.sv */
// Three-wire serial configuration slave with pair and channel maps.
// Assumes the serial clock idles between frames and that the first
// rising serial clock edge comes at least 40 ns after select falls.
`timescale 1ns/1ns
module spi_config_port
  import spi_cfg_pkg::*;
#(
  parameter int RECOVER_CYCLES = RECOVER_CYCLES_DEF
) (
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire logic i_serial_clk,
  input wire logic i_select_active_low,
  input wire logic i_sdio_in,
  output logic o_sdio_out,
  output logic o_sdio_oe,
  output logic o_pins_released,
  output logic o_lsb_first,
  output logic o_recovering,
  output logic o_datapath_reset,
  output logic [31:0] o_fast_detect_control,
  output logic [31:0] o_test_mode_select,
  output logic [15:0] o_output_format_mode
);

  // System-domain state
  logic sel_high_s;
  logic wr_tgl_s;
  logic wr_tgl_prev_q;
  logic [7:0] stall_cnt_q;
  logic idle_q;
  logic link_rst_q;
  logic lsb_first_q;
  logic ascend_q;
  logic single_instr_q;
  logic datapath_reset_q;
  logic [1:0] chan_sel_q;
  logic [1:0] pair_sel_q;
  logic [NUM_CHANS-1:0][7:0] fast_detect_q;
  logic [NUM_CHANS-1:0][7:0] test_mode_q;
  logic [NUM_PAIRS-1:0][7:0] out_mode_q;
  logic [22:0] recover_cnt_q;
  logic recovering_q;
  logic wr_pulse;
  logic wr_ok;
  logic soft_reset;

  // Link-domain state
  logic new_frame_q;
  logic [2:0] bit_cnt_q;
  logic [7:0] shift_q;
  link_phase_type phase_q;
  logic rw_q;
  logic [14:0] addr_q;
  logic [14:0] wr_addr_q;
  logic [7:0] wr_data_q;
  logic wr_tgl_q;
  logic [7:0] tx_q;
  logic drive_q;
  logic link_lsb_q;
  logic link_asc_q;
  logic sdio_out_q;
  logic sdio_oe_q;

  // Link-domain combinational terms
  logic [2:0] cnt;
  link_phase_type ph;
  logic [7:0] shift_d;
  logic byte_done;
  logic [14:0] step_addr;
  logic [14:0] rd_addr;
  logic [7:0] rd_value;

  // True when channel idx lies in a selected pair and selected channel
  function automatic logic chan_hit(input int idx, input logic [1:0] pairs,
                                    input logic [1:0] chans);
    chan_hit = pairs[idx / 2] & chans[idx % 2];
  endfunction : chan_hit

  // Select level and write toggle enter the system clock domain
  level_sync #(.WIDTH(1)) u_sel_sync (
    .i_clk(i_sys_clk),
    .i_level(i_select_active_low),
    .o_level(sel_high_s)
  );

  level_sync #(.WIDTH(1)) u_wr_sync (
    .i_clk(i_sys_clk),
    .i_level(wr_tgl_q),
    .o_level(wr_tgl_s)
  );

  // stall window: select high this long ends the frame, frees pins
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      stall_cnt_q <= 8'h00;
      idle_q <= 1'b1;
    end else if (!sel_high_s) begin
      stall_cnt_q <= 8'h00;
      idle_q <= 1'b0;
    end else if (stall_cnt_q == 8'(STALL_CYCLES - 1)) begin
      idle_q <= 1'b1;
    end else begin
      stall_cnt_q <= stall_cnt_q + 8'h01;
    end
  end

  // Registered reset copy clears the link-side settings copy
  always_ff @(posedge i_sys_clk) begin
    link_rst_q <= i_reset;
  end

  // Write strobe from the toggle; writes arriving during soft reset recovery are dropped
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      wr_tgl_prev_q <= 1'b0;
    end else begin
      wr_tgl_prev_q <= wr_tgl_s;
    end
  end

  assign wr_pulse = wr_tgl_s ^ wr_tgl_prev_q;
  assign wr_ok = wr_pulse & ~recovering_q;
  assign soft_reset = wr_ok && wr_addr_q == ADDR_PORT_CONFIG_A &&
                      (wr_data_q[CFGA_SOFT_RESET_LO] | wr_data_q[CFGA_SOFT_RESET_HI]);

  // recovery timer after a soft reset
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      recover_cnt_q <= 23'h000000;
      recovering_q <= 1'b0;
    end else if (soft_reset) begin
      recover_cnt_q <= 23'(RECOVER_CYCLES - 1);
      recovering_q <= 1'b1;
    end else if (recover_cnt_q != 23'h000000) begin
      recover_cnt_q <= recover_cnt_q - 23'h000001;
    end else begin
      recovering_q <= 1'b0;
    end
  end

  // port configuration; mirror bits are ORed so either half works
  // defaults on hard or soft reset
  always_ff @(posedge i_sys_clk) begin
    if (i_reset || soft_reset) begin
      lsb_first_q <= RST_PORT_CONFIG_A[CFGA_LSB_FIRST];
      ascend_q <= RST_PORT_CONFIG_A[CFGA_ASCEND];
      single_instr_q <= RST_PORT_CONFIG_B[CFGB_SINGLE_INSTR];
    end else if (wr_ok && wr_addr_q == ADDR_PORT_CONFIG_A) begin
      lsb_first_q <= wr_data_q[CFGA_LSB_FIRST] | wr_data_q[CFGA_LSB_FIRST_MIRROR];
      ascend_q <= wr_data_q[CFGA_ASCEND] | wr_data_q[CFGA_ASCEND_MIRROR];
    end else if (wr_ok && wr_addr_q == ADDR_PORT_CONFIG_B) begin
      single_instr_q <= wr_data_q[CFGB_SINGLE_INSTR];
    end
  end

  // Self-clearing datapath reset gives a one-cycle pulse
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      datapath_reset_q <= 1'b0;
    end else begin
      datapath_reset_q <= wr_ok && wr_addr_q == ADDR_PORT_CONFIG_B &&
                          wr_data_q[CFGB_DATAPATH_RESET];
    end
  end

  // index registers are global; low two bits select
  always_ff @(posedge i_sys_clk) begin
    if (i_reset || soft_reset) begin
      chan_sel_q <= RST_CHANNEL_SELECT;
      pair_sel_q <= RST_PAIR_SELECT;
    end else if (wr_ok && wr_addr_q == ADDR_CHANNEL_SELECT_INDEX) begin
      chan_sel_q <= wr_data_q[1:0];
    end else if (wr_ok && wr_addr_q == ADDR_PAIR_SELECT_INDEX) begin
      pair_sel_q <= wr_data_q[1:0];
    end
  end

  // one copy per channel; every selected copy is written
  for (genvar c = 0; c < NUM_CHANS; c++) begin : g_chan
    always_ff @(posedge i_sys_clk) begin
      if (i_reset || soft_reset) begin
        fast_detect_q[c] <= RST_FAST_DETECT_CONTROL;
        test_mode_q[c] <= RST_TEST_MODE_SELECT;
      end else if (wr_ok && chan_hit(c, pair_sel_q, chan_sel_q)) begin
        if (wr_addr_q == ADDR_FAST_DETECT_CONTROL) begin
          fast_detect_q[c] <= wr_data_q;
        end
        if (wr_addr_q == ADDR_TEST_MODE_SELECT) begin
          test_mode_q[c] <= wr_data_q;
        end
      end
    end
  end

  // one copy per pair; output mode defaults to 0x01
  for (genvar p = 0; p < NUM_PAIRS; p++) begin : g_pair
    always_ff @(posedge i_sys_clk) begin
      if (i_reset || soft_reset) begin
        out_mode_q[p] <= RST_OUTPUT_FORMAT_MODE;
      end else if (wr_ok && pair_sel_q[p] && wr_addr_q == ADDR_OUTPUT_FORMAT_MODE) begin
        out_mode_q[p] <= wr_data_q;
      end
    end
  end

  // Frame start marker: set while select idles, cleared by the first edge
  // first rising edge after the select fall that ends an idle restarts capture
  always_ff @(posedge i_serial_clk or posedge idle_q) begin
    if (idle_q) begin
      new_frame_q <= 1'b1;
    end else begin
      new_frame_q <= 1'b0;
    end
  end

  // A fresh frame starts at bit 0 of the instruction
  assign cnt = new_frame_q ? 3'h0 : bit_cnt_q;
  assign ph = new_frame_q ? PH_INSTR_HI : phase_q;
  // shift direction follows the bit order setting
  assign shift_d = link_lsb_q ? {i_sdio_in, shift_q[7:1]} : {shift_q[6:0], i_sdio_in};
  assign byte_done = cnt == 3'h7;
  // address steps up or down per the ascension setting
  assign step_addr = link_asc_q ? addr_q + 15'h0001 : addr_q - 15'h0001;
  assign rd_addr = (ph == PH_INSTR_LO) ? {addr_q[14:8], shift_d} : step_addr;

  // Read value for the address about to be sent. The registers only
  // change on writes from this port, which settle long before a read.
  // lowest selected channel wins; lowest selected pair wins
  always_comb begin
    rd_value = 8'h00;
    case (rd_addr)
      ADDR_PORT_CONFIG_A: begin
        rd_value[CFGA_LSB_FIRST] = lsb_first_q;
        rd_value[CFGA_LSB_FIRST_MIRROR] = lsb_first_q;
        rd_value[CFGA_ASCEND] = ascend_q;
        rd_value[CFGA_ASCEND_MIRROR] = ascend_q;
      end
      ADDR_PORT_CONFIG_B: rd_value[CFGB_SINGLE_INSTR] = single_instr_q;
      ADDR_CHANNEL_SELECT_INDEX: rd_value[1:0] = chan_sel_q;
      ADDR_PAIR_SELECT_INDEX: rd_value[1:0] = pair_sel_q;
      ADDR_FAST_DETECT_CONTROL: begin
        for (int c = NUM_CHANS - 1; c >= 0; c--) begin
          if (chan_hit(c, pair_sel_q, chan_sel_q)) begin
            rd_value = fast_detect_q[c];
          end
        end
      end
      ADDR_TEST_MODE_SELECT: begin
        for (int c = NUM_CHANS - 1; c >= 0; c--) begin
          if (chan_hit(c, pair_sel_q, chan_sel_q)) begin
            rd_value = test_mode_q[c];
          end
        end
      end
      ADDR_OUTPUT_FORMAT_MODE: begin
        for (int p = NUM_PAIRS - 1; p >= 0; p--) begin
          if (pair_sel_q[p]) begin
            rd_value = out_mode_q[p];
          end
        end
      end
      default: rd_value = 8'h00;
    endcase
  end

  // eight-bit words; position survives a select stall
  always_ff @(posedge i_serial_clk) begin
    bit_cnt_q <= cnt + 3'h1;
    shift_q <= shift_d;
  end

  // instruction then data phase, first bit is read/write
  always_ff @(posedge i_serial_clk) begin
    if (ph == PH_INSTR_HI && cnt == 3'h0) begin
      rw_q <= i_sdio_in;
    end
    if (byte_done) begin
      case (ph)
        PH_INSTR_HI: begin
          addr_q[14:8] <= link_lsb_q ? shift_d[7:1] : shift_d[6:0];
          phase_q <= PH_INSTR_LO;
        end
        PH_INSTR_LO: begin
          addr_q[7:0] <= shift_d;
          phase_q <= PH_DATA;
        end
        PH_DATA: begin
          addr_q <= step_addr;
          phase_q <= PH_DATA;
        end
        default: phase_q <= PH_INSTR_HI;
      endcase
    end else begin
      phase_q <= ph;
    end
  end

  // Completed write bytes cross as held words plus a toggle
  always_ff @(posedge i_serial_clk) begin
    if (byte_done && ph == PH_DATA && !rw_q) begin
      wr_addr_q <= addr_q;
      wr_data_q <= shift_d;
      wr_tgl_q <= ~wr_tgl_q;
    end
  end

  // Link copy of bit order and step direction, updated by the same write
  // MSB first until software selects otherwise
  always_ff @(posedge i_serial_clk or posedge link_rst_q) begin
    if (link_rst_q) begin
      link_lsb_q <= RST_PORT_CONFIG_A[CFGA_LSB_FIRST];
      link_asc_q <= RST_PORT_CONFIG_A[CFGA_ASCEND];
    end else if (byte_done && ph == PH_DATA && !rw_q && addr_q == ADDR_PORT_CONFIG_A) begin
      if (shift_d[CFGA_SOFT_RESET_LO] | shift_d[CFGA_SOFT_RESET_HI]) begin
        link_lsb_q <= RST_PORT_CONFIG_A[CFGA_LSB_FIRST];
        link_asc_q <= RST_PORT_CONFIG_A[CFGA_ASCEND];
      end else begin
        link_lsb_q <= shift_d[CFGA_LSB_FIRST] | shift_d[CFGA_LSB_FIRST_MIRROR];
        link_asc_q <= shift_d[CFGA_ASCEND] | shift_d[CFGA_ASCEND_MIRROR];
      end
    end
  end

  // Read data loads at each byte end and shifts out one bit per edge
  // turnaround happens right after the last address bit
  always_ff @(posedge i_serial_clk) begin
    if (ph == PH_INSTR_HI) begin
      drive_q <= 1'b0;
    end else if (byte_done && rw_q) begin
      drive_q <= 1'b1;
    end
    if (byte_done) begin
      tx_q <= rd_value;
    end else begin
      tx_q <= link_lsb_q ? {1'b0, tx_q[7:1]} : {tx_q[6:0], 1'b0};
    end
  end

  // Data pin driven on falling edges; select high releases it at once
  // pin driven only inside a read data phase
  always_ff @(negedge i_serial_clk or posedge i_select_active_low) begin
    if (i_select_active_low) begin
      sdio_out_q <= 1'b0;
      sdio_oe_q <= 1'b0;
    end else begin
      sdio_out_q <= link_lsb_q ? tx_q[0] : tx_q[7];
      sdio_oe_q <= drive_q;
    end
  end

  // Outputs straight from flip-flops
  assign o_sdio_out = sdio_out_q;
  assign o_sdio_oe = sdio_oe_q;
  assign o_pins_released = idle_q;
  assign o_lsb_first = lsb_first_q;
  assign o_recovering = recovering_q;
  assign o_datapath_reset = datapath_reset_q;
  assign o_fast_detect_control = fast_detect_q;
  assign o_test_mode_select = test_mode_q;
  assign o_output_format_mode = out_mode_q;

endmodule : spi_config_port
